// [hw/cts_pkg.sv]
/*
 * Shared constants and types of the current transformer supervisor:
 * measurement widths, ratio scaling, log depth, event flags and states.
 * Assumes magnitudes arrive in hundredths of nominal current.
 */
`default_nettype none

package cts_pkg;

    // =====================================================================
    // Measurement and setting widths
    // =====================================================================
    localparam int CTS_MAG_W = 16;          // Magnitudes in 0.01 x In steps
    localparam int CTS_PCT_W = 14;          // Ratios in 0.01 % steps
    localparam int CTS_TMR_W = 20;          // Delay in program cycles
    localparam int CTS_TS_W = 48;           // Millisecond time stamp
    localparam int CTS_SG_W = 3;            // Setting group number
    localparam int CTS_ID_W = 8;            // Event block identifier
    localparam int CTS_PROD_W = 32;         // Ratio cross-product width

    // =====================================================================
    // Reset values and defaults
    // =====================================================================
    localparam logic [CTS_PCT_W-1:0] CTS_PCT_FULL = 14'h2710;     // 100.00 %
    localparam logic [CTS_PCT_W-1:0] CTS_SEQ_RATIO_DFLT = 14'h1324; // 49.00 %
    localparam logic [CTS_ID_W-1:0] CTS_EVENT_BLOCK_DFLT = 8'h01;  // Arbitrary value
    localparam int CTS_BLOCK_MARGIN_MS = 5;  // Least lead of external blocking

    // =====================================================================
    // Operation log
    // =====================================================================
    localparam int CTS_LOG_DEPTH = 12;
    localparam int CTS_LOG_AW = 4;
    localparam logic [CTS_LOG_AW-1:0] CTS_LOG_LAST = 4'hB;

    // Event flag positions inside the event vector
    localparam int CTS_EV_ALARM_ON = 0;
    localparam int CTS_EV_ALARM_OFF = 1;
    localparam int CTS_EV_BLOCK_ON = 2;
    localparam int CTS_EV_BLOCK_OFF = 3;
    localparam int CTS_EV_W = 4;

    // Condition flag positions, also the fault type code in the log
    localparam int CTS_C_HIGH = 0;
    localparam int CTS_C_LOW = 1;
    localparam int CTS_C_RATIO = 2;
    localparam int CTS_C_SEQ = 3;
    localparam int CTS_C_RES = 4;
    localparam int CTS_COND_W = 5;

    // Log record: time, event flags, seven currents, remaining time, fault, group
    localparam int CTS_REC_W = CTS_TS_W + CTS_EV_W + 7 * CTS_MAG_W + CTS_TMR_W + CTS_COND_W + CTS_SG_W;

    typedef enum logic [3:0] {
        CTS_ST_IDLE = 4'h1,
        CTS_ST_TIMING = 4'h2,
        CTS_ST_ALARM = 4'h4,
        CTS_ST_BLOCKED = 4'h8
    } cts_state_t;

endpackage

`default_nettype wire

// [hw/cts_log_if.sv]
/*
 * Carrier between the supervisor and its operation log memory.
 * Assumes one clock shared by both ends.
 */
`default_nettype none

interface cts_log_if #(
    parameter int WIDTH = 8,
    parameter int AW = 4
);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [WIDTH-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [WIDTH-1:0] rd_data;

    modport writer (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

`default_nettype wire

// [hw/cts_log_mem.sv]
/*
 * Small record memory for the operation log, registered read port.
 * Assumes the writer keeps addresses below DEPTH.
 */
`default_nettype none

module cts_log_mem #(
    parameter int DEPTH = 12
)(
    input wire logic clk,
    cts_log_if.store port
);
    import cts_pkg::*;

    // =====================================================================
    // Storage
    // =====================================================================
    logic [$bits(port.wr_data)-1:0] mem [DEPTH];

    // Write side, no reset so it maps onto plain storage
    always_ff @(posedge clk)
    begin
        if (port.wr_en)
        begin
            mem[port.wr_addr] <= port.wr_data;
        end
    end

    // Read data always leaves through a register
    always_ff @(posedge clk)
    begin
        port.rd_data <= mem[port.rd_addr];
    end
endmodule

`default_nettype wire

// [hw/cts_supervisor.sv]
/*
 * Current transformer supervisor: pick-up gating, alarm delay, blocking,
 * status events with time stamps, cumulative counters and a twelve-entry log.
 * Assumes the measurement chain presents settled values at each cycle_tick
 * and supplies a running millisecond time stamp.
 */
`default_nettype none

module cts_supervisor #(
    parameter logic [cts_pkg::CTS_ID_W-1:0] EVENT_BLOCK_ID = cts_pkg::CTS_EVENT_BLOCK_DFLT,
    parameter int CNT_W = 16
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic cycle_tick,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_l1,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_l2,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_l3,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_res_calc,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_res_meas,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_pos_seq,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_neg_seq,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] high_limit,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] low_limit,
    input wire logic [cts_pkg::CTS_PCT_W-1:0] phase_ratio_limit,
    input wire logic [cts_pkg::CTS_PCT_W-1:0] sequence_ratio_limit,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] sum_diff_limit,
    input wire logic [cts_pkg::CTS_TMR_W-1:0] alarm_delay,
    input wire logic residual_input_select,
    input wire logic block_in,
    input wire logic event_on_en,
    input wire logic event_off_en,
    input wire logic [cts_pkg::CTS_TS_W-1:0] time_stamp,
    input wire logic [cts_pkg::CTS_SG_W-1:0] setting_group,
    input wire logic counter_reset,
    input wire logic [cts_pkg::CTS_LOG_AW-1:0] log_rd_addr,
    output logic supervisor_alarm_active,
    output logic supervisor_blocked,
    output logic event_valid,
    output logic [cts_pkg::CTS_EV_W-1:0] event_flags,
    output logic [cts_pkg::CTS_ID_W-1:0] supervisor_event_block,
    output logic [cts_pkg::CTS_TS_W-1:0] event_time,
    output logic [CNT_W-1:0] alarm_count,
    output logic [CNT_W-1:0] block_count,
    output logic [cts_pkg::CTS_LOG_AW-1:0] log_newest,
    output logic [cts_pkg::CTS_LOG_AW-1:0] log_fill,
    output logic [cts_pkg::CTS_REC_W-1:0] log_rd_data
);
    import cts_pkg::*;

    // =====================================================================
    // Helpers
    // =====================================================================

    // True when num/den is below pct (hundredths of a percent)
    function automatic logic ratio_below(
        input logic [CTS_MAG_W-1:0] num,
        input logic [CTS_MAG_W-1:0] den,
        input logic [CTS_PCT_W-1:0] pct
    );
        logic [CTS_PROD_W-1:0] lhs;
        logic [CTS_PROD_W-1:0] rhs;
        lhs = CTS_PROD_W'(num) * CTS_PROD_W'(CTS_PCT_FULL);
        rhs = CTS_PROD_W'(den) * CTS_PROD_W'(pct);
        return lhs < rhs;
    endfunction

    // Saturating counter step with clear; an event in the clear cycle still counts
    function automatic logic [CNT_W-1:0] count_step(
        input logic [CNT_W-1:0] cur,
        input logic inc,
        input logic clr
    );
        logic [CNT_W-1:0] base;
        base = clr ? '0 : cur;
        if (inc && (base != {CNT_W{1'b1}}))
        begin
            base = base + CNT_W'(1);
        end
        return base;
    endfunction

    // =====================================================================
    // Condition flags
    // =====================================================================
    logic [CTS_MAG_W-1:0] i_min;
    logic [CTS_MAG_W-1:0] i_max;
    logic [CTS_MAG_W-1:0] res_diff;
    logic [CTS_COND_W-1:0] cond;
    logic pickup;

    // Smallest and largest phase magnitude
    always_comb
    begin
        i_min = i_l1;
        i_max = i_l1;
        if (i_l2 < i_min) i_min = i_l2;
        if (i_l3 < i_min) i_min = i_l3;
        if (i_l2 > i_max) i_max = i_l2;
        if (i_l3 > i_max) i_max = i_l3;
    end

    // Magnitude of calculated minus measured residual current
    assign res_diff = (i_res_calc > i_res_meas) ? i_res_calc - i_res_meas : i_res_meas - i_res_calc;

    // Independent flags, each true when its condition allows activation
    always_comb
    begin
        cond[CTS_C_HIGH] = (i_max <= high_limit);
        cond[CTS_C_LOW] = (i_max >= low_limit);
        cond[CTS_C_RATIO] = ratio_below(i_min, i_max, phase_ratio_limit);
        cond[CTS_C_SEQ] = !ratio_below(i_neg_seq, i_pos_seq, sequence_ratio_limit);
        cond[CTS_C_RES] = !residual_input_select || (res_diff >= sum_diff_limit);
    end

    // Pick-up is the AND of all flags; a disabled residual check reads as met
    assign pickup = &cond;

    // =====================================================================
    // Operating state and delay timer
    // =====================================================================
    cts_state_t state_r;
    cts_state_t state_nxt;
    logic [CTS_TMR_W-1:0] timer_r;
    logic [CTS_TMR_W-1:0] timer_nxt;

    // Next state is only taken on a program cycle; blocking is sampled then
    always_comb
    begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        if (cycle_tick)
        begin
            if (!pickup)
            begin
                state_nxt = CTS_ST_IDLE;
                timer_nxt = '0;
            end
            else if (block_in)
            begin
                state_nxt = CTS_ST_BLOCKED;
                timer_nxt = '0;
            end
            else
            begin
                unique case (state_r)
                    CTS_ST_IDLE, CTS_ST_BLOCKED:
                    begin
                        if (alarm_delay == '0)
                        begin
                            state_nxt = CTS_ST_ALARM;
                        end
                        else
                        begin
                            state_nxt = CTS_ST_TIMING;
                            timer_nxt = alarm_delay - CTS_TMR_W'(1);
                        end
                    end
                    CTS_ST_TIMING:
                    begin
                        if (timer_r == '0)
                        begin
                            state_nxt = CTS_ST_ALARM;
                        end
                        else
                        begin
                            timer_nxt = timer_r - CTS_TMR_W'(1);
                        end
                    end
                    CTS_ST_ALARM: state_nxt = CTS_ST_ALARM;
                    default:
                    begin
                        state_nxt = CTS_ST_IDLE;
                        timer_nxt = '0;
                    end
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= CTS_ST_IDLE;
            timer_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
        end
    end

    // Status outputs follow the state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            supervisor_alarm_active <= 1'b0;
            supervisor_blocked <= 1'b0;
        end
        else
        begin
            supervisor_alarm_active <= (state_nxt == CTS_ST_ALARM);
            supervisor_blocked <= (state_nxt == CTS_ST_BLOCKED);
        end
    end

    // =====================================================================
    // Events
    // =====================================================================
    logic [CTS_EV_W-1:0] ev_raw;
    logic [CTS_EV_W-1:0] ev_sel;
    logic alarm_now;
    logic alarm_next;
    logic block_now;
    logic block_next;

    assign alarm_now = (state_r == CTS_ST_ALARM);
    assign alarm_next = (state_nxt == CTS_ST_ALARM);
    assign block_now = (state_r == CTS_ST_BLOCKED);
    assign block_next = (state_nxt == CTS_ST_BLOCKED);

    // Status changes; alarm off and block on may coincide
    always_comb
    begin
        ev_raw[CTS_EV_ALARM_ON] = alarm_next && !alarm_now;
        ev_raw[CTS_EV_ALARM_OFF] = alarm_now && !alarm_next;
        ev_raw[CTS_EV_BLOCK_ON] = block_next && !block_now;
        ev_raw[CTS_EV_BLOCK_OFF] = block_now && !block_next;
        ev_sel = ev_raw & {event_off_en, event_on_en, event_off_en, event_on_en};
    end

    // Event port: one-cycle pulse with flags, identifier and time stamp
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            event_valid <= 1'b0;
            event_flags <= '0;
            supervisor_event_block <= '0;
            event_time <= '0;
        end
        else
        begin
            event_valid <= |ev_sel;
            event_flags <= ev_sel;
            supervisor_event_block <= EVENT_BLOCK_ID;
            if (|ev_sel)
            begin
                event_time <= time_stamp;
            end
        end
    end

    // Cumulative counters of alarm and blocked events
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            alarm_count <= '0;
            block_count <= '0;
        end
        else
        begin
            alarm_count <= count_step(alarm_count, ev_raw[CTS_EV_ALARM_ON], counter_reset);
            block_count <= count_step(block_count, ev_raw[CTS_EV_BLOCK_ON], counter_reset);
        end
    end

    // =====================================================================
    // Operation log
    // =====================================================================
    cts_log_if #(.WIDTH(CTS_REC_W), .AW(CTS_LOG_AW)) log_bus ();
    logic [CTS_LOG_AW-1:0] wr_ptr_r;
    logic log_wr;

    assign log_wr = ev_raw[CTS_EV_ALARM_ON] || ev_raw[CTS_EV_BLOCK_ON];
    assign log_bus.wr_en = log_wr;
    assign log_bus.wr_addr = wr_ptr_r;
    assign log_bus.rd_addr = log_rd_addr;
    assign log_rd_data = log_bus.rd_data;

    // Record of the on event process data
    assign log_bus.wr_data = {time_stamp, ev_raw, i_l1, i_l2, i_l3, i_res_calc, i_res_meas,
                              i_pos_seq, i_neg_seq, timer_nxt, cond, setting_group};

    // Circular write pointer, newest index and fill level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_r <= '0;
            log_newest <= '0;
            log_fill <= '0;
        end
        else if (log_wr)
        begin
            wr_ptr_r <= (wr_ptr_r == CTS_LOG_LAST) ? '0 : wr_ptr_r + CTS_LOG_AW'(1);
            log_newest <= wr_ptr_r;
            if (log_fill != CTS_LOG_AW'(CTS_LOG_DEPTH))
            begin
                log_fill <= log_fill + CTS_LOG_AW'(1);
            end
        end
    end

    cts_log_mem #(.DEPTH(CTS_LOG_DEPTH)) u_log (
        .clk(clk),
        .port(log_bus.store)
    );
endmodule

`default_nettype wire

// [dv/cts_monitor.sv]
/*
 * Checker of the supervisor's ports: pick-up gating, delay, blocking,
 * events, counters and log fill.
 * Assumes one clock domain and the package's measurement widths.
 */
`default_nettype none

module cts_monitor
    import cts_pkg::*;
#(
    parameter logic [cts_pkg::CTS_ID_W-1:0] EVENT_BLOCK_ID = 8'h01,
    parameter int CNT_W = 16
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic cycle_tick,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_l1,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_l2,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_l3,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_res_calc,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_res_meas,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_pos_seq,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] i_neg_seq,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] high_limit,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] low_limit,
    input wire logic [cts_pkg::CTS_PCT_W-1:0] phase_ratio_limit,
    input wire logic [cts_pkg::CTS_PCT_W-1:0] sequence_ratio_limit,
    input wire logic [cts_pkg::CTS_MAG_W-1:0] sum_diff_limit,
    input wire logic [cts_pkg::CTS_TMR_W-1:0] alarm_delay,
    input wire logic residual_input_select,
    input wire logic block_in,
    input wire logic event_on_en,
    input wire logic event_off_en,
    input wire logic [cts_pkg::CTS_TS_W-1:0] time_stamp,
    input wire logic counter_reset,
    input wire logic supervisor_alarm_active,
    input wire logic supervisor_blocked,
    input wire logic event_valid,
    input wire logic [cts_pkg::CTS_EV_W-1:0] event_flags,
    input wire logic [cts_pkg::CTS_ID_W-1:0] supervisor_event_block,
    input wire logic [cts_pkg::CTS_TS_W-1:0] event_time,
    input wire logic [CNT_W-1:0] alarm_count,
    input wire logic [CNT_W-1:0] block_count,
    input wire logic [cts_pkg::CTS_LOG_AW-1:0] log_fill
);
    logic [CTS_MAG_W-1:0] mx;
    logic [CTS_MAG_W-1:0] mn;
    logic [CTS_MAG_W-1:0] rd;
    logic pk;
    logic [20:0] run_r;

    // =====================================================================
    // Reference pick-up and run of pick-up ticks
    // =====================================================================
    // Expected pick-up as the AND of all condition flags
    always_comb
    begin
        mx = (i_l1 > i_l2) ? i_l1 : i_l2;
        if (i_l3 > mx) mx = i_l3;
        mn = (i_l1 < i_l2) ? i_l1 : i_l2;
        if (i_l3 < mn) mn = i_l3;
        rd = (i_res_calc > i_res_meas) ? i_res_calc - i_res_meas : i_res_meas - i_res_calc;
        pk = mx <= high_limit && mx >= low_limit
            && 32'(mn) * 32'(CTS_PCT_FULL) < 32'(mx) * 32'(phase_ratio_limit)
            && !(32'(i_neg_seq) * 32'(CTS_PCT_FULL) < 32'(i_pos_seq) * 32'(sequence_ratio_limit))
            && (!residual_input_select || rd >= sum_diff_limit);
    end

    // Counts consecutive unblocked pick-up ticks
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            run_r <= '0;
        else if (cycle_tick)
            run_r <= (pk && !block_in) ? run_r + 21'h1 : '0;
    end

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_delay_exact: assert property ($rose(supervisor_alarm_active) |-> run_r == {1'b0, alarm_delay} + 21'h1)
        else $error("alarm rose after a wrong number of pick-up ticks");
    a_no_pickup_drop: assert property (cycle_tick && !(pk && !block_in) |=> !supervisor_alarm_active)
        else $error("alarm active without an unblocked pick-up");
    a_high_limit_stop: assert property (cycle_tick && mx > high_limit |=> !supervisor_alarm_active)
        else $error("alarm with a phase above the upper limit");
    a_low_limit_stop: assert property (cycle_tick && mx < low_limit |=> !supervisor_alarm_active)
        else $error("alarm with all phases below the lower limit");
    a_residual_stop: assert property (cycle_tick && residual_input_select && rd < sum_diff_limit
        |=> !supervisor_alarm_active)
        else $error("alarm with residual difference below its limit");
    a_block_wins: assert property (cycle_tick && block_in && pk |=> supervisor_blocked && !supervisor_alarm_active)
        else $error("blocked pick-up did not give the blocked indication");
    a_on_event_stamp: assert property ($rose(supervisor_alarm_active) && $past(event_on_en)
        |-> event_valid && event_flags[CTS_EV_ALARM_ON] && event_time == $past(time_stamp))
        else $error("alarm-on event missing or wrongly stamped");
    a_off_masked: assert property ($fell(supervisor_alarm_active) && !supervisor_blocked && !$past(event_off_en)
        |-> !event_valid)
        else $error("disabled off event was issued");
    a_block_id: assert property (!$past(rst) |-> supervisor_event_block == EVENT_BLOCK_ID)
        else $error("event block identifier wrong");
    a_count_step: assert property ($rose(supervisor_alarm_active) && !$past(counter_reset)
        |-> alarm_count == $past(alarm_count) + 1'b1)
        else $error("alarm counter did not step by one");
    a_count_clear: assert property ($past(counter_reset) && !$rose(supervisor_blocked) |-> block_count == '0)
        else $error("block counter not cleared");
    a_log_bound: assert property (log_fill <= CTS_LOG_DEPTH)
        else $error("log fill above its depth");

    c_alarm: cover property ($rose(supervisor_alarm_active));
    c_blocked: cover property ($rose(supervisor_blocked));
    c_residual: cover property (cycle_tick && residual_input_select && pk);
    c_clear: cover property (counter_reset && alarm_count != '0);
endmodule

bind cts_supervisor cts_monitor #(.EVENT_BLOCK_ID(EVENT_BLOCK_ID), .CNT_W(CNT_W)) u_mon (.*);

`default_nettype wire

// [dv/cts_meas_model.sv]
/*
 * Model of the measurement chain and blocking matrix: program-cycle
 * strobe, millisecond stamp and the blocking input.
 * Assumes the bench requests blocking through block_req.
 */
`default_nettype none

module cts_meas_model #(
    parameter int TICK_DIV = 4,
    parameter int MS_DIV = 8
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic block_req,
    output logic cycle_tick,
    output logic block_in,
    output logic [cts_pkg::CTS_TS_W-1:0] time_stamp
);
    int div_r;
    int ms_r;

    // Blocking matrix output follows the request at once
    assign block_in = block_req;

    // Strobe and stamp change off the sampling edge
    always_ff @(negedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_r <= 0;
            ms_r <= 0;
            cycle_tick <= 1'b0;
            time_stamp <= '0;
        end
        else
        begin
            div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
            cycle_tick <= (div_r == TICK_DIV - 1);
            ms_r <= (ms_r == MS_DIV - 1) ? 0 : ms_r + 1;
            if (ms_r == MS_DIV - 1)
                time_stamp <= time_stamp + 48'h1;
        end
    end
endmodule

`default_nettype wire

// [dv/tb_top.sv]
/*
 * Self-checking bench of the supervisor: delay, limits, residual check,
 * blocking, events, counters and log wrap.
 * Assumes the measurement model drives strobe, stamp and blocking.
 */
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cts_pkg::*;
    localparam logic [7:0] EVB = 8'h5A; // Arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [CTS_MAG_W-1:0] i_l1, i_l2, i_l3, i_res_calc, i_res_meas, i_pos_seq, i_neg_seq;
    logic [CTS_MAG_W-1:0] high_limit, low_limit, sum_diff_limit;
    logic [CTS_PCT_W-1:0] phase_ratio_limit, sequence_ratio_limit;
    logic [CTS_TMR_W-1:0] alarm_delay;
    logic residual_input_select, block_req, event_on_en, event_off_en, counter_reset;
    logic cycle_tick, block_in, supervisor_alarm_active, supervisor_blocked, event_valid;
    logic [CTS_TS_W-1:0] time_stamp, event_time, ts;
    logic [CTS_SG_W-1:0] setting_group;
    logic [CTS_LOG_AW-1:0] log_rd_addr, log_newest, log_fill;
    logic [CTS_EV_W-1:0] event_flags;
    logic [7:0] supervisor_event_block;
    logic [15:0] alarm_count, block_count;
    logic [CTS_REC_W-1:0] log_rd_data;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n_on = 0;
    int cyc = 0;

    cts_meas_model #(.TICK_DIV(4), .MS_DIV(8)) u_src (.*);
    cts_supervisor #(.EVENT_BLOCK_ID(EVB), .CNT_W(16)) uut (.*);

    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Waits for n program ticks and keeps the stamp of the last one
    task automatic tk(input int n);
        repeat (n)
        begin
            @(posedge clk iff cycle_tick === 1'b1);
            ts = time_stamp;
        end
        @(negedge clk);
    endtask

    task automatic meas(input logic [15:0] a, b, c, p, n, x, y);
        i_l1 = a;
        i_l2 = b;
        i_l3 = c;
        i_pos_seq = p;
        i_neg_seq = n;
        i_res_calc = x;
        i_res_meas = y;
    endtask

    task automatic normal();
        meas(16'h64, 16'h64, 16'h64, 16'h64, 16'h0, 16'h0, 16'h0);
    endtask

    task automatic fault();
        meas(16'h0, 16'h64, 16'h64, 16'h43, 16'h21, 16'h21, 16'h0);
    endtask

    // One tick of healthy currents, then one tick of the case
    task automatic case_run(input logic [15:0] a, b, c, p, n, x, y, input logic sel, e);
        normal();
        tk(1);
        residual_input_select = sel;
        meas(a, b, c, p, n, x, y);
        tk(1);
        chk(supervisor_alarm_active, e);
        n_on += e;
    endtask

    task automatic s_alarm();
        alarm_delay = 20'h2;
        fault();
        tk(2);
        chk(supervisor_alarm_active, 1'b0);
        tk(1);
        chk({supervisor_alarm_active, event_valid, event_flags, supervisor_event_block}, {2'b11, 4'h1, EVB});
        chk(event_time, ts);
        chk(alarm_count, 16'h1);
        n_on = 1;
        log_rd_addr = 4'h0;
        repeat (3) @(negedge clk);
        chk({log_fill, log_newest}, 8'h10);
        chk(log_rd_data[191:140], {ts, 4'h1});
        chk(log_rd_data[139:28], {16'h0, 16'h64, 16'h64, 16'h21, 16'h0, 16'h43, 16'h21});
        chk({log_rd_data[27:8], log_rd_data[2:0]}, {20'h0, 3'h5});
        normal();
        tk(1);
        chk({supervisor_alarm_active, event_valid, event_flags}, 6'h12);
    endtask

    task automatic s_block();
        alarm_delay = 20'h3;
        event_off_en = 1'b0;
        fault();
        tk(1);
        block_req = 1'b1;
        tk(1);
        chk({supervisor_blocked, supervisor_alarm_active, event_valid, event_flags}, 7'h54);
        chk(block_count, 16'h1);
        block_req = 1'b0;
        tk(1);
        chk({supervisor_blocked, event_valid}, 2'b00);
        tk(2);
        chk(supervisor_alarm_active, 1'b0);
        tk(1);
        chk(supervisor_alarm_active, 1'b1);
        n_on += 2;
        event_off_en = 1'b1;
    endtask

    task automatic s_wrap();
        counter_reset = 1'b1;
        @(negedge clk);
        counter_reset = 1'b0;
        chk({alarm_count, block_count}, 32'h0);
        alarm_delay = 20'h0;
        repeat (12)
        begin
            normal();
            tk(1);
            fault();
            tk(1);
            n_on++;
        end
        repeat (3) @(negedge clk);
        chk({log_fill, log_newest}, {4'hC, 4'((n_on - 1) % 12)});
        chk(alarm_count, 16'hC);
    endtask

    // Reset, then the scenarios in turn
    initial
    begin
        normal();
        high_limit = 16'h78;
        low_limit = 16'hA;
        sum_diff_limit = 16'hA;
        phase_ratio_limit = 14'h3E8;
        sequence_ratio_limit = CTS_SEQ_RATIO_DFLT;
        alarm_delay = 20'h2;
        {residual_input_select, block_req, counter_reset} = 3'b000;
        {event_on_en, event_off_en} = 2'b11;
        setting_group = 3'h5;
        log_rd_addr = 4'h0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        s_alarm();
        alarm_delay = 20'h0;
        case_run(16'h0, 16'h96, 16'h5, 16'h55, 16'h2B, 16'h0, 16'h0, 1'b0, 1'b0);
        case_run(16'h0, 16'h5, 16'h5, 16'h3, 16'h2, 16'h0, 16'h0, 1'b0, 1'b0);
        case_run(16'h0, 16'h64, 16'h64, 16'h43, 16'h1E, 16'h0, 16'h0, 1'b0, 1'b0);
        case_run(16'h0, 16'h64, 16'h64, 16'h64, 16'h31, 16'h0, 16'h0, 1'b0, 1'b1);
        case_run(16'h64, 16'h64, 16'hA, 16'h64, 16'h31, 16'h0, 16'h0, 1'b0, 1'b0);
        case_run(16'h64, 16'h64, 16'h9, 16'h64, 16'h31, 16'h0, 16'h0, 1'b0, 1'b1);
        case_run(16'h0, 16'h64, 16'h64, 16'h43, 16'h21, 16'h21, 16'h21, 1'b1, 1'b0);
        case_run(16'h0, 16'h64, 16'h64, 16'h43, 16'h21, 16'h21, 16'h17, 1'b1, 1'b1);
        case_run(16'h0, 16'h64, 16'h64, 16'h43, 16'h21, 16'h21, 16'h18, 1'b1, 1'b0);
        residual_input_select = 1'b0;
        normal();
        tk(1);
        s_block();
        s_wrap();
        end_of_test();
    end
endmodule

`default_nettype wire
